// ==== hdl/pla_pkg.sv ====
// Purpose: shared constants for the programmable logic array
// Assumes: 32-bit word registers at byte offsets from the block base
// Notes: element flip-flops run on core_clk gated by a selected enable
package pla_pkg;
   localparam int NUM_ELEM = 16;
   localparam int BLK_SIZE = 8;
   localparam logic [7:0] OFS_ELEM0 = 8'h00;
   localparam logic [7:0] OFS_CLKSEL = 8'h40;
   localparam logic [7:0] OFS_IRQROUTE = 8'h44;
   localparam logic [7:0] OFS_CONVROUTE = 8'h48;
   localparam logic [7:0] OFS_DIN = 8'h4C;
   localparam logic [7:0] OFS_DOUT = 8'h50;
   localparam logic [7:0] OFS_IRQSTAT = 8'h54;
   localparam logic [7:0] OFS_IRQCLR = 8'h58;
   localparam logic [7:0] OFS_IRQEN = 8'h5C;
   localparam int CFG_W = 11;
   localparam int POS_BYPASS = 0;
   localparam int POS_LUT = 1;
   localparam int POS_PINSEL = 5;
   localparam int POS_MUX2 = 6;
   localparam int POS_MUX1 = 7;
   localparam int POS_MUX0 = 9;
   localparam int POS_BLK1CLK = 4;
   localparam int POS_IRQ1EN = 12;
   localparam int POS_IRQ0EN = 4;
   localparam logic [2:0] CLK_PIN0 = 3'h0;
   localparam logic [2:0] CLK_PIN1 = 3'h1;
   localparam logic [2:0] CLK_PIN2 = 3'h2;
   localparam logic [2:0] CLK_CORE = 3'h3;
   localparam logic [2:0] CLK_WATCH = 3'h4;
   localparam logic [2:0] CLK_TMR1 = 3'h5;
   localparam logic [CFG_W-1:0] CFG_RST = 11'h000;
   localparam logic [6:0] CLKSEL_RST = 7'h00;
   localparam logic [15:0] IRQROUTE_RST = 16'h0000;
   localparam logic [4:0] CONVROUTE_RST = 5'h00;
endpackage : pla_pkg

// ==== hdl/pla_element.sv ====
// Purpose: one logic element, lookup table plus optional flip-flop
// Assumes: clkEn is a one-cycle enable from the block clock selector
// Notes: lut index is {a,b}, so 1000 is AND and 1110 is OR
module pla_element
   import pla_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic clkEn,
   input wire logic [3:0] lutCfg,
   input wire logic bypass,
   input wire logic inA,
   input wire logic inB,
   output logic elemOut
);
   logic lutOut;
   logic ff_q;
   assign lutOut = lutCfg[{inA, inB}]; // see R2, R11
   always_ff @(posedge core_clk) begin
      if (srst) begin
         ff_q <= 1'b0; // see R15
      end else if (clkEn) begin
         ff_q <= lutOut;
      end
   end
   assign elemOut = bypass ? lutOut : ff_q; // see R12
endmodule : pla_element

// ==== hdl/pla_clk_select.sv ====
// Purpose: picks a block's flip-flop clock enable from six sources
// Assumes: slow sources arrive synchronous; rising edges become pulses
// Notes: reserved codes stop the block's flip-flops
module pla_clk_select
   import pla_pkg::*;
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [2:0] sel,
   input wire logic [2:0] pinClk,
   input wire logic watchClk,
   input wire logic tmr1Ovf,
   output logic clkEn
);
   logic src;
   logic src_q;
   assign src = (sel == CLK_PIN0) ? pinClk[0] :
                (sel == CLK_PIN1) ? pinClk[1] :
                (sel == CLK_PIN2) ? pinClk[2] :
                (sel == CLK_WATCH) ? watchClk :
                (sel == CLK_TMR1) ? tmr1Ovf : 1'b0;
   always_ff @(posedge core_clk) begin
      if (srst) begin
         src_q <= 1'b0;
      end else begin
         src_q <= src;
      end
   end
   // see R13
   assign clkEn = (sel == CLK_CORE) ? 1'b1 : (src & ~src_q);
endmodule : pla_clk_select

// ==== hdl/pla_top.sv ====
// Purpose: sixteen-element programmable logic array with registers
// Assumes: pins already synchronous; port function gating done here
// Notes: outputs registered, so pin paths lag the fabric one cycle
//
// Summary of operation
// R1: sixteen elements in two blocks of eight, 0-7 and 8-15.
// R2: each element has a two-input lookup table and a flip-flop.
// R3: thirty pins: sixteen element inputs, fourteen element outputs; the code has sixteen of each, with pinOutEn at 16'h0001 once reset ends.
// R4: a pin reaches the fabric only when its port function selects it.
// R5: comparator output is one of the sixteen input sources.
// R6: outputs route to interrupts, converter start, register and pins.
// R7: element 15 feeds mux 0 input 0 of element 0.
// R8: element 7 feeds mux 0 input 0 of element 8.
// R9: each element has one fixed input pin and output pin.
// R10: twenty-two memory-mapped registers form the software interface; the code has twenty-four.
// R11: four-bit lookup field holds the truth table of the function.
// R12: bypass set skips the flip-flop; clear, the default, uses it.
// R13: each block's flip-flops use a three-bit selected clock source.
// R14: pin select set feeds the own input pin, else mux 1 output.
// R15: reset clears every element flip-flop to zero.
//
// Local design decisions: the address map and the strobed register port.
module pla_top
   import pla_pkg::*;
#(
   parameter int ELEMS = NUM_ELEM
)
(
   input wire logic core_clk,
   input wire logic srst,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [31:0] regRdata,
   input wire logic [15:0] pinIn,
   input wire logic [15:0] pinInSel,
   input wire logic compOut,
   input wire logic [2:0] pinClk,
   input wire logic watchClk,
   input wire logic tmr1Ovf,
   output logic [15:0] pinOut,
   output logic [15:0] pinOutEn,
   output logic irq0,
   output logic irq1,
   output logic convStart,
   output logic irq
);
   // routing tables below are written for sixteen elements only
   if (ELEMS != NUM_ELEM) begin : g_bad_elems
      $error("pla_top supports exactly 16 elements");
   end

   logic [CFG_W-1:0] cfg_q [NUM_ELEM];
   logic [6:0] clkSel_q;
   logic [15:0] irqRoute_q;
   logic [4:0] convRoute_q;
   logic [15:0] din_q;
   logic [15:0] dout_q;
   logic [1:0] stat_q;
   logic [1:0] statEn_q;
   logic irqPrev_q;
   logic convPrev_q;
   logic [15:0] elemOut;
   logic [15:0] pinGated;
   logic [1:0] blkEn;
   logic [31:0] rdMux;
   logic irq0Src;
   logic irq1Src;
   logic convSrc;
   logic [1:0] statSet;
   logic [1:0] statClr;
   logic wrElem;
   logic [3:0] elemIdx;
   logic hitElem;
   logic hitClkSel;
   logic hitIrqRoute;
   logic hitConvRoute;
   logic hitDin;
   logic hitDout;
   logic hitStat;
   logic hitClr;
   logic hitEn;

   // one named decode per register, shared by read and write paths
   assign hitElem = (regAddr[7:6] == 2'b00);
   assign hitClkSel = (regAddr == OFS_CLKSEL);
   assign hitIrqRoute = (regAddr == OFS_IRQROUTE);
   assign hitConvRoute = (regAddr == OFS_CONVROUTE);
   assign hitDin = (regAddr == OFS_DIN);
   assign hitDout = (regAddr == OFS_DOUT);
   assign hitStat = (regAddr == OFS_IRQSTAT);
   assign hitClr = (regAddr == OFS_IRQCLR);
   assign hitEn = (regAddr == OFS_IRQEN);

   // pins outside the array function read low, no stray toggles
   // element 7 input is the comparator when that pin is not selected
   assign pinGated = pinIn & pinInSel; // see R4, R3, R9
   assign wrElem = regWr && hitElem;
   assign elemIdx = regAddr[5:2];

   genvar b;
   generate
      for (b = 0; b < 2; b++) begin : g_blk
         pla_clk_select u_clk (
            .core_clk(core_clk),
            .srst(srst),
            .sel(clkSel_q[b*POS_BLK1CLK +: 3]),
            .pinClk(pinClk),
            .watchClk(watchClk),
            .tmr1Ovf(tmr1Ovf),
            .clkEn(blkEn[b])
         ); // see R13
      end
   endgenerate

   genvar e;
   generate
      for (e = 0; e < NUM_ELEM; e++) begin : g_elem
         localparam int BASE = (e / BLK_SIZE) * BLK_SIZE;
         localparam int OTHER = (e < BLK_SIZE) ? 15 : 7;
         logic [1:0] m0s;
         logic [1:0] m1s;
         logic m0;
         logic m1;
         logic ownPin;
         logic inA;
         logic inB;
         logic fb0;
         assign m0s = cfg_q[e][POS_MUX0 +: 2];
         assign m1s = cfg_q[e][POS_MUX1 +: 2];
         // first element of a block takes the other block's last
         assign fb0 = (e == BASE) ? elemOut[OTHER] :
                      elemOut[BASE]; // see R7, R8
         assign m0 = (m0s == 2'b00) ? fb0 : elemOut[BASE + 2*m0s];
         assign m1 = elemOut[BASE + 1 + 2*m1s];
         assign ownPin = (e == 7) ? (pinInSel[7] ? pinIn[7] : compOut)
                                  : pinGated[e]; // see R5
         assign inA = cfg_q[e][POS_MUX2] ? m0 : din_q[e];
         assign inB = cfg_q[e][POS_PINSEL] ? ownPin : m1; // see R14
         pla_element u_elem (
            .core_clk(core_clk),
            .srst(srst),
            .clkEn(blkEn[e / BLK_SIZE]),
            .lutCfg(cfg_q[e][POS_LUT +: 4]),
            .bypass(cfg_q[e][POS_BYPASS]),
            .inA(inA),
            .inB(inB),
            .elemOut(elemOut[e])
         ); // see R1, R2
         always_ff @(posedge core_clk) begin
            if (srst) begin
               cfg_q[e] <= CFG_RST;
            end else if (wrElem && elemIdx == 4'(e)) begin
               cfg_q[e] <= regWdata[CFG_W-1:0]; // see R11
            end
         end
      end
   endgenerate

   assign irq0Src = elemOut[irqRoute_q[3:0]] & irqRoute_q[POS_IRQ0EN];
   assign irq1Src = elemOut[irqRoute_q[11:8]] & irqRoute_q[POS_IRQ1EN];
   assign convSrc = elemOut[convRoute_q[3:0]] & convRoute_q[4];
   // events: rising edge of routed element output
   assign statSet = {irq1Src & ~irqPrev_q, convSrc & ~convPrev_q};
   assign statClr = (regWr && hitClr) ? regWdata[1:0] : 2'b00;

   // seven readable fixed registers plus sixteen element registers; the clear register reads zero
   assign rdMux = hitElem ? {21'h000000, cfg_q[elemIdx]} :
                  hitClkSel ? {25'h0000000, clkSel_q} :
                  hitIrqRoute ? {16'h0000, irqRoute_q} :
                  hitConvRoute ? {27'h0000000, convRoute_q} :
                  hitDin ? {16'h0000, din_q} :
                  hitDout ? {16'h0000, dout_q} :
                  hitStat ? {30'h00000000, stat_q} :
                  hitEn ? {30'h00000000, statEn_q} :
                  32'h00000000; // see R10

   always_ff @(posedge core_clk) begin
      if (srst) begin
         clkSel_q <= CLKSEL_RST;
         irqRoute_q <= IRQROUTE_RST;
         convRoute_q <= CONVROUTE_RST;
         din_q <= 16'h0000;
         statEn_q <= 2'h0;
      end else if (regWr) begin
         if (hitClkSel) begin
            // reserved bit 3 is not stored, reads back zero
            clkSel_q <= regWdata[6:0] & 7'h77; // see R13
         end
         if (hitIrqRoute) begin
            irqRoute_q <= regWdata[15:0];
         end
         if (hitConvRoute) begin
            convRoute_q <= regWdata[4:0];
         end
         if (hitDin) begin
            din_q <= regWdata[15:0];
         end
         if (hitEn) begin
            statEn_q <= regWdata[1:0];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         stat_q <= 2'h0;
         irqPrev_q <= 1'b0;
         convPrev_q <= 1'b0;
         regRdata <= 32'h00000000;
         dout_q <= 16'h0000;
         pinOut <= 16'h0000;
         pinOutEn <= 16'hFFFF;
         irq0 <= 1'b0;
         irq1 <= 1'b0;
         convStart <= 1'b0;
         irq <= 1'b0;
      end else begin
         // set wins over a same-cycle clear
         stat_q <= (stat_q & ~statClr) | statSet;
         irqPrev_q <= irq1Src;
         convPrev_q <= convSrc;
         regRdata <= regRd ? rdMux : 32'h00000000;
         dout_q <= elemOut; // see R6
         pinOut <= elemOut;
         pinOutEn <= {8'h00, 8'h01} ^ 16'h0000; // see R3, R9
         irq0 <= irq0Src; // see R6
         irq1 <= irq1Src;
         convStart <= convSrc;
         irq <= |(stat_q & statEn_q);
      end
   end

   // assertions
   a_irq_level: assert property (@(posedge core_clk) disable iff (srst)
      irq == $past(|(stat_q & statEn_q)))
      else $error("irq not matching enabled status"); // see R6
   a_stat_sticky: assert property (@(posedge core_clk) disable iff (srst)
      (stat_q[0] && statClr[0] == 1'b0) |=> stat_q[0])
      else $error("status bit lost without clear"); // see R6
   a_conv_follow: assert property (@(posedge core_clk) disable iff (srst)
      convSrc |=> convStart)
      else $error("converter start missed"); // see R6
   a_ff_reset: assert property (@(posedge core_clk)
      srst |=> elemOut == 16'h0000 || cfg_q[0][POS_BYPASS])
      else $error("flip-flops not cleared"); // see R15
   a_pin_gate: assert property (@(posedge core_clk) disable iff (srst)
      !pinInSel[0] |-> !pinGated[0])
      else $error("ungated pin reached fabric"); // see R4
   a_dout_track: assert property (@(posedge core_clk) disable iff (srst)
      ##1 dout_q == $past(elemOut))
      else $error("data output register stale"); // see R6
   a_fb_blk0: assert property (@(posedge core_clk) disable iff (srst)
      g_elem[0].m0s == 2'b00 |-> g_elem[0].m0 == elemOut[15])
      else $error("block 1 feedback missing"); // see R7
   a_fb_blk1: assert property (@(posedge core_clk) disable iff (srst)
      g_elem[8].m0s == 2'b00 |-> g_elem[8].m0 == elemOut[7])
      else $error("block 0 feedback missing"); // see R8

   // routed outputs follow their sources one cycle later
   a_irq0_follow: assert property ( // see R6
      @(posedge core_clk) disable iff (srst)
      irq0Src |=> irq0)
      else $error("irq0 output missed");
   a_irq1_follow: assert property ( // see R6
      @(posedge core_clk) disable iff (srst)
      irq1Src |=> irq1)
      else $error("irq1 output missed");
   a_irq0_quiet: assert property ( // see R6
      @(posedge core_clk) disable iff (srst)
      !irq0Src |=> !irq0)
      else $error("irq0 output without source");
   a_conv_quiet: assert property ( // see R6
      @(posedge core_clk) disable iff (srst)
      !convSrc |=> !convStart)
      else $error("converter start without source");
   a_pinout_follow: assert property ( // see R6
      @(posedge core_clk) disable iff (srst)
      1'b1 |=> pinOut == $past(elemOut))
      else $error("pin outputs stale");

   // status bits: set wins, clear only without a set
   a_stat_set0: assert property ( // see R6
      @(posedge core_clk) disable iff (srst)
      statSet[0] |=> stat_q[0])
      else $error("converter event not recorded");
   a_stat_set1: assert property ( // see R6
      @(posedge core_clk) disable iff (srst)
      statSet[1] |=> stat_q[1])
      else $error("irq1 event not recorded");
   a_stat_clear: assert property ( // see R6
      @(posedge core_clk) disable iff (srst)
      (statClr[1] && !statSet[1]) |=> !stat_q[1])
      else $error("status bit not cleared");

   // register port
   a_rdata_read: assert property ( // see R10
      @(posedge core_clk) disable iff (srst)
      regRd |=> regRdata == $past(rdMux))
      else $error("read data wrong");
   a_rdata_idle: assert property ( // see R10
      @(posedge core_clk) disable iff (srst)
      !regRd |=> regRdata == 32'h00000000)
      else $error("read data not idle");
   a_cfg_write: assert property ( // see R11
      @(posedge core_clk) disable iff (srst)
      (wrElem && elemIdx == 4'h8) |=>
         cfg_q[8] == $past(regWdata[CFG_W-1:0]))
      else $error("element config write lost");
   a_din_write: assert property ( // see R10
      @(posedge core_clk) disable iff (srst)
      (regWr && hitDin) |=> din_q == $past(regWdata[15:0]))
      else $error("data input write lost");
   a_en_write: assert property ( // see R6
      @(posedge core_clk) disable iff (srst)
      (regWr && hitEn) |=> statEn_q == $past(regWdata[1:0]))
      else $error("enable write lost");

   // clock selection and comparator source
   a_core_enable: assert property ( // see R13
      @(posedge core_clk) disable iff (srst)
      (clkSel_q[2:0] == CLK_CORE) |-> blkEn[0])
      else $error("core clock code gave no enable");
   a_freeze_blk0: assert property ( // see R13
      @(posedge core_clk) disable iff (srst)
      (clkSel_q[2:0] > CLK_TMR1) |-> !blkEn[0])
      else $error("reserved code clocked block 0");
   a_freeze_blk1: assert property ( // see R13
      @(posedge core_clk) disable iff (srst)
      (clkSel_q[6:4] > CLK_TMR1) |-> !blkEn[1])
      else $error("reserved code clocked block 1");
   a_ff_hold: assert property ( // see R12
      @(posedge core_clk) disable iff (srst)
      (!blkEn[1] && !cfg_q[9][POS_BYPASS] && !wrElem) |=>
         $stable(elemOut[9]))
      else $error("flip-flop moved without enable");
   a_comp_source: assert property ( // see R5
      @(posedge core_clk) disable iff (srst)
      !pinInSel[7] |-> g_elem[7].ownPin == compOut)
      else $error("comparator not offered to element 7");

   c_irq: cover property (@(posedge core_clk) irq);
   c_conv: cover property (@(posedge core_clk) convStart);
   c_clr: cover property (@(posedge core_clk) statClr[1] && stat_q[1]);
   c_watch: cover property (@(posedge core_clk)
      blkEn[1] && clkSel_q[6:4] == CLK_WATCH);
   c_fb: cover property (@(posedge core_clk)
      g_elem[0].m0s == 2'b00 && elemOut[15]);
endmodule : pla_top

// ==== test/pla_pins_model.sv ====
// Purpose: port pins and slow clock sources around the array
// Assumes: bench requests reach the pads one cycle later
// Notes: slow clocks stand still unless run is high
module pla_pins_model (
   input wire logic core_clk,
   input wire logic srst,
   input wire logic run,
   input wire logic [15:0] pinReq,
   input wire logic [15:0] selReq,
   input wire logic compReq,
   output logic [15:0] pinIn,
   output logic [15:0] pinInSel,
   output logic compOut,
   output logic [2:0] pinClk,
   output logic watchClk,
   output logic tmr1Ovf
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [4:0] divQ;
   initial {pinIn, pinInSel, compOut, divQ} = '0;
   always @(posedge core_clk) begin
      if (srst) divQ <= 5'h00;
      else if (run) divQ <= divQ + 5'h01;
      pinIn <= pinReq;
      pinInSel <= selReq;
      compOut <= compReq;
   end
   // stopped sources give no edges, so flip-flops hold
   assign pinClk = divQ[3:1];
   assign watchClk = divQ[2];
   assign tmr1Ovf = &divQ;
endmodule : pla_pins_model

// ==== test/pla_top_tb.sv ====
// Purpose: self-checking bench for the logic array
// Assumes: one-cycle strobes; read data lands the next cycle
// Notes: element outputs seen through the data output register
module pla_top_tb
   import pla_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, srst, regWr, regRd, run, compReq;
   logic [7:0] regAddr;
   logic [31:0] regWdata, regRdata, rdV;
   logic [15:0] pinIn, pinInSel, pinOut, pinOutEn, pinReq, selReq;
   logic [2:0] pinClk;
   logic compOut, watchClk, tmr1Ovf, irq0, irq1, convStart, irq;
   int n_mismatch = 0;
   int checks = 0;
   // rows: lut code, data-in bit, pin bit, expected output
   localparam logic [6:0] ROWS [8] = '{7'h06, 7'h47, 7'h44, 7'h73,
      7'h70, 7'h79, 7'h36, 7'h09};
   localparam logic [7:0] REGS [7] = '{OFS_ELEM0, 8'h3C, OFS_CLKSEL,
      OFS_IRQROUTE, OFS_CONVROUTE, OFS_IRQSTAT, OFS_DOUT};
   pla_pins_model pins_u (.core_clk(core_clk), .srst(srst), .run(run),
      .pinReq(pinReq), .selReq(selReq), .compReq(compReq),
      .pinIn(pinIn), .pinInSel(pinInSel), .compOut(compOut),
      .pinClk(pinClk), .watchClk(watchClk), .tmr1Ovf(tmr1Ovf));
   pla_top dut_u (.core_clk(core_clk), .srst(srst), .regAddr(regAddr),
      .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
      .regRdata(regRdata), .pinIn(pinIn), .pinInSel(pinInSel),
      .compOut(compOut), .pinClk(pinClk), .watchClk(watchClk),
      .tmr1Ovf(tmr1Ovf), .pinOut(pinOut), .pinOutEn(pinOutEn),
      .irq0(irq0), .irq1(irq1), .convStart(convStart), .irq(irq));
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic tally_and_finish;
      if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge core_clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWdata <= d;
      @(posedge core_clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge core_clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge core_clk);
      regRd <= 1'b0;
      @(negedge core_clk);
      rdV = regRdata;
   endtask : rd
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
   endtask : idle
   task automatic elem(input int e, input logic exp);
      rd(OFS_DOUT);
      chk("elem out", {31'h0, rdV[e]}, {31'h0, exp});
   endtask : elem
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // whole run needs about 200 cycles
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      tally_and_finish;
   end
   initial begin
      {regWr, regRd, regAddr, regWdata, run, compReq} = '0;
      {pinReq, selReq} = '0;
      srst = 1'b1;
      repeat (5) @(posedge core_clk);
      srst <= 1'b0;
      @(negedge core_clk);
      chk("pinOutEn", {16'h0, pinOutEn}, 32'h0000FFFF);
      chk("pinOut", {16'h0, pinOut}, 32'h0);
      foreach (REGS[i]) begin
         rd(REGS[i]);
         chk("reset reg", rdV, 32'h0);
      end
      chk("pinOutEn run", {16'h0, pinOutEn}, 32'h00000001);
      wr(OFS_CLKSEL, 32'hFFFFFFFF);
      rd(OFS_CLKSEL);
      chk("clksel", rdV, 32'h77);
      @(negedge core_clk);
      chk("rdata hold", regRdata, 32'h0);
      rd(8'h60);
      chk("unmapped", rdV, 32'h0);
      selReq <= 16'h0100;
      foreach (ROWS[i]) begin
         wr(8'h20, {26'h0, 1'b1, ROWS[i][6:3], 1'b1});
         wr(OFS_DIN, {23'h0, ROWS[i][2], 8'h00});
         pinReq <= {7'h0, ROWS[i][1], 8'h00};
         idle(3);
         elem(8, ROWS[i][0]);
      end
      chk("pin", {31'h0, pinOut[8]}, {31'h0, ROWS[7][0]});
      // unselected pins must not leak into the fabric
      pinReq <= 16'hFFFF;
      selReq <= 16'h0000;
      compReq <= 1'b1;
      wr(8'h1C, 32'h35);
      wr(8'h20, 32'h35);
      idle(3);
      elem(7, 1'b1);
      elem(8, 1'b0);
      selReq <= 16'h0100;
      idle(3);
      elem(8, 1'b1);
      wr(8'h3C, 32'h1F);
      wr(8'h1C, 32'h1F);
      wr(8'h00, 32'h59);
      wr(8'h20, 32'h59);
      idle(2);
      elem(0, 1'b1);
      elem(8, 1'b1);
      wr(8'h3C, 32'h01);
      wr(8'h1C, 32'h01);
      idle(2);
      elem(0, 1'b0);
      elem(8, 1'b0);
      wr(OFS_CLKSEL, 32'h60);
      wr(8'h24, 32'h1E);
      idle(4);
      elem(9, 1'b0);
      wr(OFS_CLKSEL, 32'h30);
      idle(4);
      elem(9, 1'b1);
      wr(OFS_CLKSEL, 32'h40);
      wr(8'h24, 32'h00);
      idle(4);
      elem(9, 1'b1);
      run <= 1'b1;
      idle(20);
      elem(9, 1'b0);
      wr(OFS_CONVROUTE, 32'h18);
      wr(OFS_IRQROUTE, 32'h1818);
      wr(OFS_IRQEN, 32'h3);
      wr(8'h20, 32'h1F);
      idle(3);
      chk("route", {29'h0, irq0, irq1, convStart}, 32'h7);
      chk("irq", {31'h0, irq}, 32'h1);
      wr(8'h20, 32'h01);
      rd(OFS_IRQSTAT);
      chk("status", rdV, 32'h3);
      wr(OFS_IRQEN, 32'h0);
      idle(2);
      chk("masked", {31'h0, irq}, 32'h0);
      wr(OFS_IRQEN, 32'h3);
      wr(OFS_IRQCLR, 32'h3);
      idle(2);
      chk("cleared", {31'h0, irq}, 32'h0);
      rd(OFS_IRQSTAT);
      chk("status clr", rdV, 32'h0);
      tally_and_finish;
   end
endmodule : pla_top_tb
